// *** rtl/pmec_defs.vh ***
// constants for the pci master error and clock-run block
`ifndef PMEC_DEFS_VH
`define PMEC_DEFS_VH
`define PMEC_ADDR_CMD 12'h000
`define PMEC_ADDR_STS 12'h004
`define PMEC_ADDR_CFG 12'h008
`define PMEC_ADDR_REQ 12'h00c
`define PMEC_ADDR_ST2 12'h010
`define PMEC_CMD_INV_PERMIT 4
`define PMEC_CMD_PERR_RESP 6
`define PMEC_CMD_SERR_EN 8
`define PMEC_STS_DATA_PAR 8
`define PMEC_STS_SIG_SERR 14
`define PMEC_STS_DET_PAR 15
`define PMEC_CFG_RD_ALIGN 2
`define PMEC_CFG_LINE_STOP 3
`define PMEC_CFG_INV_PERMIT 4
`define PMEC_CFG_CLKRUN_EN 5
`define PMEC_OP_MEM_WRITE 4'h7
`define PMEC_OP_MEM_WR_INV 4'hf
`define PMEC_OP_MEM_RD_MULT 4'hc
`define PMEC_OP_MEM_RD_LINE 4'he
`define PMEC_CLS_8 8'h08
`define PMEC_CLS_16 8'h10
`define PMEC_CLKRUN_HOLD 4'h8
`endif

// *** rtl/pmec_burst_ctl.v ***
// burst length and line-boundary stop decision for one master burst
`default_nettype none
module pmec_burst_ctl (
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire xfer,
  input wire [7:0] cls,
  input wire [7:0] start_word,
  input wire [7:0] limit,
  input wire limit_en,
  input wire line_stop,
  input wire inv_cmd,
  input wire inv_ok,
  input wire read_dir,
  input wire rd_align,
  input wire fifo_near,
  output reg stop_req
);
  reg [7:0] count_reg;
  reg [7:0] word_reg;
  wire [7:0] word_next;
  wire at_line_end;
  wire limit_hit;
  assign word_next = word_reg + 8'h01;
  assign at_line_end = ((word_next & (cls - 8'h01)) == 8'h00) && (cls != 8'h00);
  assign limit_hit = limit_en && ((count_reg + 8'h01) >= limit);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 8'h00;
      word_reg <= 8'h00;
    end else if (start) begin
      count_reg <= 8'h00;
      word_reg <= start_word;
    end else if (xfer) begin
      count_reg <= count_reg + 8'h01;
      word_reg <= word_next;
    end
  end
  always @* begin
    stop_req = 1'b0;
    if (read_dir) begin
      if (rd_align && fifo_near && at_line_end)
        stop_req = 1'b1;
      if (limit_hit && (!rd_align || at_line_end))
        stop_req = 1'b1;
    end else begin
      if (inv_cmd && !inv_ok && at_line_end)
        stop_req = 1'b1;
      if (!inv_cmd && line_stop && at_line_end)
        stop_req = 1'b1;
      if (limit_hit && (!inv_cmd || at_line_end))
        stop_req = 1'b1;
    end
  end
endmodule // pmec_burst_ctl
`default_nettype wire

// *** rtl/pmec_top.v ***
// pci master error reporting, command choice, burst limits and clock-run
// Behaviour
// - target data parity error sets status 15
// - target perr only when response bit set
// - parity error never ends a transaction
// - target accesses end with a disconnect
// - address error without both enables: status 15
// - both enables: status 14,15, one-clock serr
// - address parity checked on every transaction
// - read multiple for data, line for control
// - control writes plain, data may invalidate
// - transmit bursts bounded by target, fifo, limit
// - receive bursts bounded by target, threshold, limit
// - invalidate write needs all six preconditions
// - failed precondition falls back to plain write
// - invalidate: all enables, whole lines moved
// - lapsed precondition stops at line end
// - line-stop option ends plain write at line
// - read align stops near full fifo
// - limit hand-over only at line boundary; the code waits for it only on aligned reads and invalidates
// - master parity error: perr and status 8
// - master read parity error also sets 15
// - device asserts clock-run to keep clock
// - clock-run disabled: always claim the clock
//
// Decided for this implementation: the register offsets and register access over APB.
`default_nettype none
`include "pmec_defs.vh"
module pmec_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire addr_par_err,
  input wire tgt_data_par_err,
  input wire tgt_access_done,
  input wire mst_data_par_err,
  input wire burst_req,
  input wire burst_write,
  input wire burst_ctrl,
  input wire [31:0] burst_addr,
  input wire [7:0] fifo_dwords,
  input wire [7:0] buf_dwords,
  input wire fifo_near_full,
  input wire target_stop,
  input wire data_xfer,
  input wire bus_busy,
  input wire clkrun_n_in,
  output reg perr_n,
  output reg serr_n,
  output reg tgt_stop_n,
  output reg [3:0] bus_cmd,
  output reg [3:0] byte_en_n,
  output reg burst_active,
  output reg burst_end,
  output reg clkrun_n_out,
  output reg clkrun_n_oe
);
  localparam ST_IDLE = 2'd0;
  localparam ST_BURST = 2'd1;
  localparam ST_END = 2'd2;
  reg [15:0] cmd_reg;
  reg [15:0] sts_reg;
  reg [7:0] cfg_reg;
  reg [7:0] cls_reg;
  reg [7:0] tx_limit_reg;
  reg [7:0] rx_limit_reg;
  reg [1:0] state_reg;
  reg inv_cmd_reg;
  reg read_dir_reg;
  reg [3:0] hold_reg;
  reg [31:0] rdata_next;
  reg [15:0] sts_next;
  reg [15:0] sts_set;
  reg addr_hit;
  wire wr_acc;
  wire rd_acc;
  wire perr_resp;
  wire serr_en;
  wire cls_ok;
  wire inv_ok;
  wire stop_req;
  wire [7:0] line_dw;
  wire [7:0] cur_limit;
  wire [7:0] start_word;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign perr_resp = cmd_reg[`PMEC_CMD_PERR_RESP];
  assign serr_en = cmd_reg[`PMEC_CMD_SERR_EN];
  assign cls_ok = (cls_reg == `PMEC_CLS_8) || (cls_reg == `PMEC_CLS_16);
  assign line_dw = cls_reg;
  assign start_word = burst_addr[9:2];
  assign inv_ok = cls_ok && ((burst_addr[9:2] & (line_dw - 8'h01)) == 8'h00) &&
    (fifo_dwords >= line_dw) && (buf_dwords >= line_dw) &&
    cmd_reg[`PMEC_CMD_INV_PERMIT] && cfg_reg[`PMEC_CFG_INV_PERMIT];
  assign cur_limit = burst_write ? rx_limit_reg : tx_limit_reg;
  pmec_burst_ctl u_burst (
    .pclk(pclk),
    .presetn(presetn),
    .start(state_reg == ST_IDLE && burst_req),
    .xfer(state_reg == ST_BURST && data_xfer),
    .cls(cls_reg),
    .start_word(start_word),
    .limit(cur_limit),
    .limit_en(cur_limit != 8'h00),
    .line_stop(cfg_reg[`PMEC_CFG_LINE_STOP]),
    .inv_cmd(inv_cmd_reg),
    .inv_ok(inv_ok_live(1'b0)),
    .read_dir(read_dir_reg),
    .rd_align(cfg_reg[`PMEC_CFG_RD_ALIGN]),
    .fifo_near(fifo_near_full),
    .stop_req(stop_req)
  );
  // lapse check during a burst ignores alignment, which only matters at start
  function inv_ok_live;
    input dummy;
    begin
      inv_ok_live = cls_ok && (fifo_dwords >= line_dw) && (buf_dwords >= line_dw) &&
        cmd_reg[`PMEC_CMD_INV_PERMIT] && cfg_reg[`PMEC_CFG_INV_PERMIT];
    end
  endfunction
  always @* begin
    sts_set = 16'h0000;
    if (tgt_data_par_err)
      sts_set[`PMEC_STS_DET_PAR] = 1'b1;
    if (addr_par_err) begin
      sts_set[`PMEC_STS_DET_PAR] = 1'b1;
      if (serr_en && perr_resp)
        sts_set[`PMEC_STS_SIG_SERR] = 1'b1;
    end
    if (mst_data_par_err && perr_resp)
      sts_set[`PMEC_STS_DATA_PAR] = 1'b1;
    if (mst_data_par_err && burst_active && read_dir_reg)
      sts_set[`PMEC_STS_DET_PAR] = 1'b1;
  end
  always @* begin
    sts_next = sts_reg | sts_set;
    // write one to clear at the taken edge; a same-cycle event wins, even on a set bit
    if (wr_acc && !pready && paddr == `PMEC_ADDR_STS)
      sts_next = (sts_reg & ~pwdata[15:0]) | sts_set;
  end
  always @* begin
    rdata_next = 32'h0000_0000;
    addr_hit = 1'b1;
    if (paddr == `PMEC_ADDR_CMD)
      rdata_next = {16'h0000, cmd_reg};
    else if (paddr == `PMEC_ADDR_STS)
      rdata_next = {16'h0000, sts_reg};
    else if (paddr == `PMEC_ADDR_CFG)
      rdata_next = {16'h0000, cls_reg, cfg_reg};
    else if (paddr == `PMEC_ADDR_REQ)
      rdata_next = {16'h0000, rx_limit_reg, tx_limit_reg};
    else if (paddr == `PMEC_ADDR_ST2)
      rdata_next = {24'h000000, 1'b0, inv_cmd_reg, read_dir_reg, burst_active, bus_cmd};
    else
      addr_hit = 1'b0;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg <= 16'h0000;
      sts_reg <= 16'h0000;
      cfg_reg <= 8'h00;
      cls_reg <= 8'h00;
      tx_limit_reg <= 8'h00;
      rx_limit_reg <= 8'h00;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      sts_reg <= sts_next;
      // one wait state: answer one cycle after the access phase opens
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_hit;
      if (rd_acc && !pready)
        prdata <= rdata_next;
      if (wr_acc && !pready) begin
        if (paddr == `PMEC_ADDR_CMD)
          cmd_reg <= pwdata[15:0];
        else if (paddr == `PMEC_ADDR_CFG) begin
          cfg_reg <= pwdata[7:0];
          cls_reg <= pwdata[15:8];
        end else if (paddr == `PMEC_ADDR_REQ) begin
          tx_limit_reg <= pwdata[7:0];
          rx_limit_reg <= pwdata[15:8];
        end
      end
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      perr_n <= 1'b1;
      serr_n <= 1'b1;
      tgt_stop_n <= 1'b1;
    end else begin
      perr_n <= !((tgt_data_par_err || mst_data_par_err) && perr_resp);
      serr_n <= !(addr_par_err && serr_en && perr_resp);
      // parity errors do not cause a stop
      tgt_stop_n <= !tgt_access_done;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      inv_cmd_reg <= 1'b0;
      read_dir_reg <= 1'b0;
      bus_cmd <= `PMEC_OP_MEM_WRITE;
      byte_en_n <= 4'hf;
      burst_active <= 1'b0;
      burst_end <= 1'b0;
    end else begin
      burst_end <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (burst_req) begin
            state_reg <= ST_BURST;
            burst_active <= 1'b1;
            read_dir_reg <= !burst_write;
            byte_en_n <= 4'h0;
            if (!burst_write) begin
              inv_cmd_reg <= 1'b0;
              bus_cmd <= burst_ctrl ? `PMEC_OP_MEM_RD_LINE : `PMEC_OP_MEM_RD_MULT;
            end else if (!burst_ctrl && inv_ok) begin
              inv_cmd_reg <= 1'b1;
              bus_cmd <= `PMEC_OP_MEM_WR_INV;
            end else begin
              inv_cmd_reg <= 1'b0;
              bus_cmd <= `PMEC_OP_MEM_WRITE;
            end
          end
        end
        ST_BURST: begin
          // invalidate stops only on line ends or a target stop
          if (target_stop || (data_xfer && stop_req) ||
              (!inv_cmd_reg && !read_dir_reg && fifo_dwords == 8'h00)) begin
            state_reg <= ST_END;
            burst_end <= 1'b1;
          end
        end
        ST_END: begin
          // command reselected at next start
          state_reg <= ST_IDLE;
          burst_active <= 1'b0;
          byte_en_n <= 4'hf;
          inv_cmd_reg <= 1'b0;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= 4'h0;
      clkrun_n_out <= 1'b0;
      clkrun_n_oe <= 1'b0;
    end else begin
      clkrun_n_out <= 1'b0;
      if (bus_busy || burst_req || burst_active)
        hold_reg <= `PMEC_CLKRUN_HOLD;
      else if (hold_reg != 4'h0)
        hold_reg <= hold_reg - 4'h1;
      if (!cfg_reg[`PMEC_CFG_CLKRUN_EN])
        clkrun_n_oe <= 1'b1;
      // keep or restore clock when needed
      // host release seen as high input
      else
        clkrun_n_oe <= (hold_reg != 4'h0) || ((bus_busy || burst_req) && clkrun_n_in);
    end
  end
endmodule // pmec_top
`default_nettype wire

// *** sim/pmec_host_model.sv ***
// behavioural host bridge and memory target for master bursts
`default_nettype none
module pmec_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic burst_active,
  input wire logic bus_busy,
  input wire logic slow,
  input wire logic clkrun_n_oe,
  output logic data_xfer,
  output logic target_stop,
  output logic clkrun_n_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt;
  logic [4:0] idle;
  logic tog;
  // host releases line
  // open drain with pull-up: low while the host runs the clock or the device claims it
  assign clkrun_n_in = !(idle != 5'h1f || clkrun_n_oe);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'h0;
      idle <= 5'h0;
      tog <= 1'b0;
      data_xfer <= 1'b0;
      target_stop <= 1'b0;
    end else begin
      tog <= ~tog;
      idle <= (bus_busy || burst_active) ? 5'h0 : idle + {4'h0, idle != 5'h1f};
      // slow target inserts a wait every other cycle
      data_xfer <= burst_active && cnt < 3'h4 && (!slow || tog);
      cnt <= burst_active ? cnt + {2'h0, data_xfer} : 3'h0;
      target_stop <= burst_active && cnt == 3'h3 && data_xfer;
    end
  end
endmodule // pmec_host_model
`default_nettype wire

// *** sim/pmec_assertions.sv ***
// concurrent checks on the ports of the pci master error block
`default_nettype none
`include "pmec_defs.vh"
module pmec_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire addr_par_err,
  input wire tgt_data_par_err,
  input wire tgt_access_done,
  input wire burst_write,
  input wire burst_ctrl,
  input wire perr_n,
  input wire serr_n,
  input wire tgt_stop_n,
  input wire [3:0] bus_cmd,
  input wire [3:0] byte_en_n,
  input wire burst_active,
  input wire clkrun_n_out,
  input wire clkrun_n_oe
);
  logic [31:0] cmd_reg;
  logic [31:0] cfg_reg;
  // the design takes a write on the edge that raises pready, so the shadow follows that edge
  wire wr = psel & penable & !pready & pwrite;
  wire sys_en = cmd_reg[`PMEC_CMD_PERR_RESP] & cmd_reg[`PMEC_CMD_SERR_EN];
  // shadow copies, since enables live in registers the ports do not show
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg <= 32'h0;
      cfg_reg <= 32'h0;
    end else if (wr && paddr == `PMEC_ADDR_CMD) begin
      cmd_reg <= pwdata;
    end else if (wr && paddr == `PMEC_ADDR_CFG) begin
      cfg_reg <= pwdata;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_serr_blip;
    !serr_n ##1 serr_n;
  endsequence
  sequence s_new_burst;
    $rose(burst_active);
  endsequence
  a_serr_pulse: assert property (addr_par_err && sys_en |=> s_serr_blip)
    else $error("serr pulse");
  a_serr_cause: assert property (!serr_n |-> $past(addr_par_err) && $past(sys_en))
    else $error("serr cause");
  a_perr_tgt: assert property (tgt_data_par_err && cmd_reg[6] |=> !perr_n)
    else $error("perr missing");
  a_perr_cause: assert property (!perr_n |-> $past(cmd_reg[6]))
    else $error("perr unexpected");
  a_disc_stop: assert property (tgt_access_done |=> !tgt_stop_n)
    else $error("no disconnect");
  a_no_early: assert property (!tgt_stop_n |-> $past(tgt_access_done))
    else $error("early stop");
  a_read_cmd: assert property (s_new_burst ##0 !$past(burst_write) |->
    bus_cmd == ($past(burst_ctrl) ? `PMEC_OP_MEM_RD_LINE : `PMEC_OP_MEM_RD_MULT))
    else $error("read command");
  a_ctrl_write: assert property (s_new_burst ##0 $past(burst_write & burst_ctrl) |->
    bus_cmd == `PMEC_OP_MEM_WRITE)
    else $error("control write");
  a_inv_bytes: assert property (burst_active && bus_cmd == `PMEC_OP_MEM_WR_INV |->
    byte_en_n == 4'h0)
    else $error("invalidate bytes");
  a_claim_off: assert property ((!cfg_reg[`PMEC_CFG_CLKRUN_EN]) [*3] |-> clkrun_n_oe)
    else $error("clock not claimed");
  a_pull_low: assert property (clkrun_n_oe |-> !clkrun_n_out)
    else $error("claim level");
endmodule // pmec_chk
bind pmec_top pmec_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .addr_par_err(addr_par_err), .tgt_data_par_err(tgt_data_par_err),
  .tgt_access_done(tgt_access_done), .burst_write(burst_write), .burst_ctrl(burst_ctrl),
  .perr_n(perr_n), .serr_n(serr_n), .tgt_stop_n(tgt_stop_n), .bus_cmd(bus_cmd),
  .byte_en_n(byte_en_n), .burst_active(burst_active), .clkrun_n_out(clkrun_n_out),
  .clkrun_n_oe(clkrun_n_oe));
`default_nettype wire

// *** sim/pci_master_error_and_clock_run_tb_top.sv ***
// self-checking bench for the pci master error and clock-run block
`default_nettype none
`include "pmec_defs.vh"
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH %0t %s", $time, m); end end
module pci_master_error_and_clock_run_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slv, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, a, badr = 0;
  logic ape = 0, tpe = 0, tad = 0, mpe = 0, breq = 0, bwr = 0, bctl = 0;
  logic [7:0] fifo = 8'h10, bufd = 8'h10;
  logic fnf = 0, bbusy = 0, slow = 0, dx, ts, crin, perr_n, serr_n, tsn, bact, bend, cro, croe;
  logic [3:0] cmd, ben;
  int errors = 0, samples_checked = 0;
  pmec_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .addr_par_err(ape), .tgt_data_par_err(tpe), .tgt_access_done(tad), .mst_data_par_err(mpe),
    .burst_req(breq), .burst_write(bwr), .burst_ctrl(bctl), .burst_addr(badr),
    .fifo_dwords(fifo), .buf_dwords(bufd), .fifo_near_full(fnf), .target_stop(ts),
    .data_xfer(dx), .bus_busy(bbusy), .clkrun_n_in(crin), .perr_n(perr_n), .serr_n(serr_n),
    .tgt_stop_n(tsn), .bus_cmd(cmd), .byte_en_n(ben), .burst_active(bact), .burst_end(bend),
    .clkrun_n_out(cro), .clkrun_n_oe(croe));
  pmec_host_model host (.pclk(pclk), .presetn(presetn), .burst_active(bact), .bus_busy(bbusy),
    .slow(slow), .clkrun_n_oe(croe), .data_xfer(dx), .target_stop(ts), .clkrun_n_in(crin));
  initial forever #12.5 pclk = ~pclk;
  task automatic summarize();
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    rd = prdata;
    slv = pslverr;
    if (n >= 20) errors++;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic ev(input int k);
    @(posedge pclk);
    {ape, tpe, tad, mpe} <= 4'h8 >> k;
    @(posedge pclk);
    {ape, tpe, tad, mpe} <= 4'h0;
    repeat (3) @(posedge pclk);
  endtask
  function automatic logic [3:0] exp_cmd(input logic w, input logic c, input logic inv);
    if (!w) return c ? `PMEC_OP_MEM_RD_LINE : `PMEC_OP_MEM_RD_MULT;
    return (!c && inv) ? `PMEC_OP_MEM_WR_INV : `PMEC_OP_MEM_WRITE;
  endfunction
  task automatic burst(input logic w, input logic c, input logic [3:0] e, input logic pe);
    int n;
    n = 0;
    @(posedge pclk);
    bwr <= w;
    bctl <= c;
    breq <= 1;
    do @(posedge pclk); while (bact !== 1'b1 && ++n < 50);
    breq <= 0;
    mpe <= pe;
    `CHK(cmd, e, "burst command")
    @(posedge pclk);
    mpe <= 0;
    while (bact === 1'b1 && ++n < 200) @(posedge pclk);
    `CHK(n < 200, 1'b1, "burst hang")
  endtask
  initial begin
    a = $urandom(10);
    repeat (16) @(posedge pclk);
    presetn <= 1;
    apb(0, `PMEC_ADDR_STS, 0);
    `CHK(rd, 32'h0, "status reset")
    apb(0, 12'h014, 0);
    `CHK(slv, 1'b1, "unmapped")
    `CHK(croe, 1'b1, "clock claim off")
    for (int i = 0; i < 4; i++) begin
      apb(1, `PMEC_ADDR_CMD, {23'h0, i[1], 1'b0, i[0], 6'h0});
      apb(1, `PMEC_ADDR_STS, 32'hffff);
      ev(0);
      apb(0, `PMEC_ADDR_STS, 0);
      `CHK(rd[15:14], {1'b1, i == 3}, "address parity")
      apb(1, `PMEC_ADDR_STS, 32'hffff);
      ev(1);
      ev(2);
      apb(0, `PMEC_ADDR_STS, 0);
      `CHK(rd[15:8], 8'h80, "target parity")
    end
    apb(1, `PMEC_ADDR_CMD, 32'h40);
    for (int j = 0; j < 4; j++) begin
      apb(1, `PMEC_ADDR_STS, 32'hffff);
      burst(j[1], j[0], exp_cmd(j[1], j[0], 0), 1);
      apb(0, `PMEC_ADDR_STS, 0);
      `CHK(rd[15:8], j[1] ? 8'h01 : 8'h81, "master parity")
    end
    apb(1, `PMEC_ADDR_CMD, 32'h50);
    apb(1, `PMEC_ADDR_CFG, 32'h0830);
    bbusy <= 1;
    repeat (4) @(posedge pclk);
    `CHK(croe, 1'b1, "clock claim busy")
    bbusy <= 0;
    for (int k = 0; k < 30; k++) begin
      a = $urandom;
      badr <= a & 32'hffffffe4;
      fifo <= {3'h0, a[12:8]};
      bufd <= {3'h0, a[17:13]};
      fnf <= a[18];
      slow <= a[19];
      burst(a[20], a[21], exp_cmd(a[20], a[21], !a[2] && a[12:8] >= 8 && a[17:13] >= 8), 0);
    end
    summarize();
  end
  initial begin
    #1000000;
    errors++;
    summarize();
  end
endmodule // pci_master_error_and_clock_run_tb_top
`default_nettype wire
